// File: eeprom_control_defines.svh
/*
  Register offsets, field positions, reset values and timing counts for the
  EEPROM control unit. Assumes a 100 MHz clock and byte-wide registers.
*/
`ifndef EEPROM_CONTROL_DEFINES_SVH
`define EEPROM_CONTROL_DEFINES_SVH

`define ADDR_STORED_CRC 8'h2f
`define ADDR_PROG_COUNT 8'h30
`define ADDR_NV_CTL 8'h31
`define ADDR_LIVE_CRC 8'h32
`define ADDR_UNLOCK 8'h38

// Unlock code value is arbitrary.
`define UNLOCK_CODE 8'h5a

`define BIT_LIVE_TO_SRAM 6
`define BIT_CRC_ERROR 5
`define BIT_AUTO_CRC 4
`define BIT_EE_TO_LIVE 3
`define BIT_BUSY 2
`define BIT_ERASE 1
`define BIT_PROGRAM 0

`define RST_BYTE 8'h00
`define RST_AUTO_CRC 1'b1
`define COUNT_MAX 8'hff
`define CRC_INIT 8'h00
`define CRC_POLY 8'h07

`define NV_WORDS 32
`define LIVE_WORDS 5'd30
`define COUNT_WORD 5'd30
`define CRC_WORD 5'd31
`define LAST_WORD 5'd31

`define CLK_PERIOD_NS 10
`define ERASE_TIME_MS 115
`define PROGRAM_TIME_MS 115
`define ERASE_CYCLES ((`ERASE_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define PROGRAM_CYCLES ((`PROGRAM_TIME_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// File: eeprom_control_pkg.sv
/*
  Types and the CRC byte step for the EEPROM control unit.
  Assumes the defines header is on the include path.
*/
`include "eeprom_control_defines.svh"

package eeprom_control_pkg;

  typedef enum logic [2:0] {
    S_LOAD,
    S_IDLE,
    S_COPY,
    S_ERASE,
    S_PROG,
    S_RELOAD
  } nv_state_t;

  typedef logic [7:0] byte_t;
  typedef logic [4:0] word_addr_t;

  // One byte step of a CRC-8, MSB first.
  function automatic byte_t crc8_step(input byte_t crc, input byte_t data);
    byte_t c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ((c << 1) ^ `CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

endpackage

// File: nv_array_if.sv
/*
  Carrier between the control unit and the EEPROM/SRAM store.
  Assumes both ends share ref_clk.
*/
`timescale 1ns/1ps

interface nv_array_if;
  import eeprom_control_pkg::*;
  word_addr_t addr;
  logic sram_we;
  byte_t sram_wdata;
  byte_t sram_rdata;
  byte_t ee_rdata;
  logic erase_go;
  logic prog_go;
  logic auto_crc;

  modport ctrl (
    output addr, sram_we, sram_wdata, erase_go, prog_go, auto_crc,
    input sram_rdata, ee_rdata
  );
  modport store (
    input addr, sram_we, sram_wdata, erase_go, prog_go, auto_crc,
    output sram_rdata, ee_rdata
  );
endinterface

// File: nv_store.sv
/*
  EEPROM array and its SRAM staging array. Erase and program act in the
  cycle of their pulse; the control unit times the phases around them.
  Assumes both arrays start erased and then hold what was last written.
*/
`timescale 1ns/1ps

module nv_store
  import eeprom_control_pkg::*;
(
  input wire logic ref_clk,  // System clock
  nv_array_if.store nv       // Array access from the control unit
);

  // Both arrays leave the factory erased, so a first load reads zeros.
  byte_t ee_mem [`NV_WORDS] = '{default: `RST_BYTE};
  byte_t sram_mem [`NV_WORDS] = '{default: `RST_BYTE};
  byte_t sram_crc;

  // CRC over the image that a program would store.
  always_comb
  begin
    sram_crc = `CRC_INIT;
    for (int i = 0; i < 30; i++)
    begin
      sram_crc = crc8_step(sram_crc, sram_mem[i]);
    end
  end

  assign nv.sram_rdata = sram_mem[nv.addr];
  assign nv.ee_rdata = ee_mem[nv.addr];

  always_ff @(posedge ref_clk)
  begin
    if (nv.sram_we)
    begin
      sram_mem[nv.addr] <= nv.sram_wdata;
    end
  end

  // The cycle count survives an erase and saturates on program.
  for (genvar g = 0; g < `NV_WORDS; g++)
  begin : g_word
    always_ff @(posedge ref_clk)
    begin
      if (g == `COUNT_WORD)
      begin
        if (nv.prog_go && ee_mem[g] != `COUNT_MAX)
        begin
          ee_mem[g] <= ee_mem[g] + 8'h01;
        end
      end
      else if (nv.erase_go)
      begin
        ee_mem[g] <= `RST_BYTE;
      end
      else if (nv.prog_go)
      begin
        if (g == `CRC_WORD && nv.auto_crc)
        begin
          ee_mem[g] <= sram_crc;
        end
        else
        begin
          ee_mem[g] <= sram_mem[g];
        end
      end
    end
  end

endmodule

// File: eeprom_control_unit.sv
/*
  EEPROM control unit: stored and live CRC, cycle counter, control byte,
  unlock guard, register/EEPROM transfers and erase/program timing.
  Assumes the serial front end hands over byte accesses and marks the end
  of each bus transaction, and that live registers answer reads at once.
*/
`timescale 1ns/1ps

module eeprom_control_unit
  import eeprom_control_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = `ERASE_CYCLES,
  parameter int unsigned PROGRAM_CYCLES = `PROGRAM_CYCLES
)
(
  input wire logic ref_clk,        // System clock, 100 MHz
  input wire logic rst,            // Synchronous reset, active high
  input wire logic reg_wr,         // Register write strobe
  input wire logic reg_rd,         // Register read strobe
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata,// Register write data
  input wire logic txn_end,        // End of a bus transaction
  output logic [7:0] reg_rdata,    // Register read data
  output logic rd_hold,            // Reads refused during EEPROM load
  output logic live_we,            // Live register write strobe
  output logic [4:0] live_addr,    // Live register address
  output logic [7:0] live_wdata,   // Live register write data
  input wire logic [7:0] live_rdata// Live register read data
);

  nv_array_if nv ();

  nv_store u_store (
    .ref_clk (ref_clk),
    .nv      (nv.store)
  );

  nv_state_t state_r, state_nxt;
  word_addr_t addr_r, addr_nxt;
  logic [23:0] timer_r, timer_nxt;
  byte_t stored_crc_r, stored_crc_nxt;
  byte_t count_r, count_nxt;
  byte_t live_crc_r, live_crc_nxt;
  byte_t run_crc_r, run_crc_nxt;
  logic crc_err_r, crc_err_nxt;
  logic auto_crc_r, auto_crc_nxt;
  logic erase_pend_r, erase_pend_nxt;
  logic prog_pend_r, prog_pend_nxt;
  logic txn_unlock_r, txn_unlock_nxt;
  logic txn_open_r, txn_open_nxt;
  logic armed_r, armed_nxt;
  byte_t rdata_r, rdata_nxt;

  logic ctl_wr;
  logic start_req;
  logic busy;
  byte_t ctl_view;

  assign ctl_wr = reg_wr && reg_addr == `ADDR_NV_CTL;
  assign start_req = ctl_wr && armed_r
    && (reg_wdata[`BIT_ERASE] || reg_wdata[`BIT_PROGRAM]);
  assign busy = state_r == S_ERASE || state_r == S_PROG
    || state_r == S_RELOAD;

  always_comb
  begin
    ctl_view = 8'h00;
    ctl_view[`BIT_LIVE_TO_SRAM] = state_r == S_COPY;
    ctl_view[`BIT_CRC_ERROR] = crc_err_r;
    ctl_view[`BIT_AUTO_CRC] = auto_crc_r;
    ctl_view[`BIT_EE_TO_LIVE] = state_r == S_LOAD;
    ctl_view[`BIT_BUSY] = busy;
    ctl_view[`BIT_ERASE] = erase_pend_r;
    ctl_view[`BIT_PROGRAM] = prog_pend_r;
  end

  // Unlock tracking: a transaction counts as an unlock only if every
  // access in it was the unlock write with the right code.
  always_comb
  begin
    txn_unlock_nxt = txn_unlock_r;
    txn_open_nxt = txn_open_r;
    armed_nxt = armed_r;
    if (reg_wr || reg_rd)
    begin
      txn_unlock_nxt = (txn_unlock_r || !txn_open_r)
        && reg_wr && reg_addr == `ADDR_UNLOCK
        && reg_wdata == `UNLOCK_CODE;
      txn_open_nxt = 1'b1;
    end
    if (txn_end)
    begin
      armed_nxt = txn_unlock_nxt;
      txn_unlock_nxt = 1'b0;
      txn_open_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      txn_unlock_r <= 1'b0;
      txn_open_r <= 1'b0;
      armed_r <= 1'b0;
    end
    else
    begin
      txn_unlock_r <= txn_unlock_nxt;
      txn_open_r <= txn_open_nxt;
      armed_r <= armed_nxt;
    end
  end

  // Read path.
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (reg_rd && state_r != S_LOAD)
    begin
      case (reg_addr)
        `ADDR_STORED_CRC: rdata_nxt = stored_crc_r;
        `ADDR_PROG_COUNT: rdata_nxt = count_r;
        `ADDR_NV_CTL: rdata_nxt = ctl_view;
        `ADDR_LIVE_CRC: rdata_nxt = live_crc_r;
        default: rdata_nxt = `RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rdata_r <= `RST_BYTE;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign rd_hold = state_r == S_LOAD;

  // Array and live-register strobes follow the sequencer state.
  assign nv.addr = addr_r;
  assign nv.sram_we = state_r == S_COPY;
  assign nv.sram_wdata = live_rdata;
  assign nv.auto_crc = auto_crc_r;
  assign nv.erase_go = state_r == S_ERASE && timer_r == 24'h000000;
  assign nv.prog_go = state_r == S_PROG && timer_r == 24'h000000;
  assign live_addr = addr_r;
  assign live_wdata = nv.ee_rdata;
  assign live_we = state_r == S_LOAD && addr_r < `LIVE_WORDS;

  // Sequencer.
  always_comb
  begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    timer_nxt = timer_r;
    stored_crc_nxt = stored_crc_r;
    count_nxt = count_r;
    live_crc_nxt = live_crc_r;
    run_crc_nxt = run_crc_r;
    crc_err_nxt = crc_err_r;
    auto_crc_nxt = auto_crc_r;
    erase_pend_nxt = erase_pend_r;
    prog_pend_nxt = prog_pend_r;
    if (ctl_wr)
    begin
      auto_crc_nxt = reg_wdata[`BIT_AUTO_CRC];
    end
    case (state_r)
      S_LOAD:
      begin
        if (addr_r < `LIVE_WORDS)
        begin
          run_crc_nxt = crc8_step(run_crc_r, nv.ee_rdata);
        end
        if (addr_r == `COUNT_WORD)
        begin
          count_nxt = nv.ee_rdata;
        end
        addr_nxt = addr_r + 5'd1;
        if (addr_r == `LAST_WORD)
        begin
          stored_crc_nxt = nv.ee_rdata;
          live_crc_nxt = run_crc_r;
          crc_err_nxt = run_crc_r != nv.ee_rdata;
          addr_nxt = 5'd0;
          state_nxt = S_IDLE;
        end
      end
      S_IDLE:
      begin
        addr_nxt = 5'd0;
        run_crc_nxt = `CRC_INIT;
        if (start_req)
        begin
          erase_pend_nxt = reg_wdata[`BIT_ERASE];
          prog_pend_nxt = reg_wdata[`BIT_PROGRAM];
          if (reg_wdata[`BIT_ERASE])
          begin
            timer_nxt = 24'(ERASE_CYCLES - 1);
            state_nxt = S_ERASE;
          end
          else
          begin
            timer_nxt = 24'(PROGRAM_CYCLES - 1);
            state_nxt = S_PROG;
          end
        end
        else if (ctl_wr && reg_wdata[`BIT_EE_TO_LIVE])
        begin
          state_nxt = S_LOAD;
        end
        else if (ctl_wr && reg_wdata[`BIT_LIVE_TO_SRAM])
        begin
          state_nxt = S_COPY;
        end
      end
      S_COPY:
      begin
        addr_nxt = addr_r + 5'd1;
        if (addr_r == `LIVE_WORDS - 5'd1)
        begin
          addr_nxt = 5'd0;
          state_nxt = S_IDLE;
        end
      end
      S_ERASE:
      begin
        timer_nxt = timer_r - 24'd1;
        if (timer_r == 24'h000000)
        begin
          erase_pend_nxt = 1'b0;
          if (prog_pend_r)
          begin
            timer_nxt = 24'(PROGRAM_CYCLES - 1);
            state_nxt = S_PROG;
          end
          else
          begin
            addr_nxt = `COUNT_WORD;
            state_nxt = S_RELOAD;
          end
        end
      end
      S_PROG:
      begin
        timer_nxt = timer_r - 24'd1;
        if (timer_r == 24'h000000)
        begin
          prog_pend_nxt = 1'b0;
          addr_nxt = `COUNT_WORD;
          state_nxt = S_RELOAD;
        end
      end
      S_RELOAD:
      begin
        addr_nxt = addr_r + 5'd1;
        if (addr_r == `COUNT_WORD)
        begin
          count_nxt = nv.ee_rdata;
        end
        else
        begin
          stored_crc_nxt = nv.ee_rdata;
          addr_nxt = 5'd0;
          state_nxt = S_IDLE;
        end
      end
      default:
      begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_r <= S_LOAD;
      addr_r <= 5'd0;
      timer_r <= 24'h000000;
      stored_crc_r <= `RST_BYTE;
      count_r <= `RST_BYTE;
      live_crc_r <= `RST_BYTE;
      run_crc_r <= `CRC_INIT;
      crc_err_r <= 1'b0;
      auto_crc_r <= `RST_AUTO_CRC;
      erase_pend_r <= 1'b0;
      prog_pend_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      timer_r <= timer_nxt;
      stored_crc_r <= stored_crc_nxt;
      count_r <= count_nxt;
      live_crc_r <= live_crc_nxt;
      run_crc_r <= run_crc_nxt;
      crc_err_r <= crc_err_nxt;
      auto_crc_r <= auto_crc_nxt;
      erase_pend_r <= erase_pend_nxt;
      prog_pend_r <= prog_pend_nxt;
    end
  end

endmodule

// File: eeprom_control_unit_asserts.sv
/*
  Port checker for eeprom_control_unit, bound into every instance.
  Assumes the defines header is on the include path.
*/
`timescale 1ns/1ps
`include "eeprom_control_defines.svh"
module eeprom_control_unit_asserts
  import eeprom_control_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = 20,
  parameter int unsigned PROGRAM_CYCLES = 20
)
(
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic txn_end, // Transaction end
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic rd_hold, // Load running
  input wire logic live_we, // Live write
  input wire logic [4:0] live_addr, // Live address
  input wire logic [7:0] live_wdata, // Live data
  input wire logic [7:0] live_rdata // Live readback
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  logic [5:0] we_cnt_r;

  // Counts live register writes within one load.
  always_ff @(posedge ref_clk)
  begin
    if (rst || !rd_hold)
      we_cnt_r <= 6'h00;
    else if (live_we)
      we_cnt_r <= we_cnt_r + 6'h01;
  end

  reset_load_a: assert property ($fell(rst) |-> rd_hold[*8])
    else $error("no load after reset");
  load_cause_a: assert property ($rose(rd_hold) |->
    $past(reg_wr && reg_addr == `ADDR_NV_CTL && reg_wdata[3]))
    else $error("load started without request");
  word_count_a: assert property ($fell(rd_hold) |-> we_cnt_r == 6'h1e)
    else $error("load wrote wrong word count");
  we_in_load_a: assert property (live_we |-> rd_hold)
    else $error("live write outside load");
  addr_step_a: assert property (live_we && $past(live_we) &&
    !$past(rst) |-> live_addr == $past(live_addr) + 5'h01)
    else $error("live address skipped");
  held_read_a: assert property (reg_rd && rd_hold |=> $stable(reg_rdata))
    else $error("read served during load");
  unlock_read_a: assert property (reg_rd && !rd_hold &&
    reg_addr == `ADDR_UNLOCK |=> reg_rdata == 8'h00)
    else $error("unlock register read nonzero");
  start_busy_a: assert property (reg_rd && !rd_hold &&
    reg_addr == `ADDR_NV_CTL |=> reg_rdata[2] || reg_rdata[1:0] == 2'h0)
    else $error("start bit set without busy");
endmodule

bind eeprom_control_unit eeprom_control_unit_asserts #(
  .ERASE_CYCLES(ERASE_CYCLES),
  .PROGRAM_CYCLES(PROGRAM_CYCLES)
) i_asserts (
  .ref_clk(ref_clk),
  .rst(rst),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .txn_end(txn_end),
  .reg_rdata(reg_rdata),
  .rd_hold(rd_hold),
  .live_we(live_we),
  .live_addr(live_addr),
  .live_wdata(live_wdata),
  .live_rdata(live_rdata)
);

// File: host_model.sv
/*
  Serial host model: one access per transaction, strobes at clock edges.
  Assumes the device takes an access on the edge its strobe is seen.
*/
`timescale 1ns/1ps
`include "eeprom_control_defines.svh"
module host_model
(
  input wire logic ref_clk, // Clock
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic rd_hold, // Reads held off
  output logic reg_wr, // Write strobe
  output logic reg_rd, // Read strobe
  output logic [7:0] reg_addr, // Address
  output logic [7:0] reg_wdata, // Write data
  output logic txn_end // Transaction end
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    txn_end = 1'b0;
  end

  // Released lines show the inverse so stale values are never trusted.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    txn_end <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    txn_end <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic unlock();
    wr(`ADDR_UNLOCK, `UNLOCK_CODE);
  endtask

  task automatic rd(input logic [7:0] a, input bit wait_ok,
                    output logic [7:0] d);
    int n;
    n = 0;
    #1;
    while (wait_ok && rd_hold !== 1'b0 && n < 100)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    txn_end <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    txn_end <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
endmodule

// File: test_eeprom_control_unit.sv
/*
  Testbench for eeprom_control_unit with a host model and live registers.
  Assumes short erase and program counts set by parameter.
*/
`timescale 1ns/1ps
`include "eeprom_control_defines.svh"
module test_eeprom_control_unit
  import eeprom_control_pkg::*;
;
  localparam int unsigned EC = 20;
  localparam int unsigned PC = 20;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr, reg_rd, txn_end, rd_hold, live_we;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, live_wdata, live_rdata;
  logic [4:0] live_addr;
  logic [7:0] live_mem [30];
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;

  always #5 ref_clk = ~ref_clk;
  assign live_rdata = live_mem[live_addr];

  always @(posedge ref_clk)
  begin
    if (live_we)
      live_mem[live_addr] <= live_wdata;
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      give_verdict();
    end
  end

  eeprom_control_unit #(.ERASE_CYCLES(EC), .PROGRAM_CYCLES(PC)) i_dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .txn_end(txn_end),
    .reg_rdata(reg_rdata),
    .rd_hold(rd_hold),
    .live_we(live_we),
    .live_addr(live_addr),
    .live_wdata(live_wdata),
    .live_rdata(live_rdata)
  );

  host_model i_host (
    .ref_clk(ref_clk),
    .reg_rdata(reg_rdata),
    .rd_hold(rd_hold),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .txn_end(txn_end)
  );

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] crc_ref();
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 30; i++)
    begin
      c = c ^ 8'(i * 7 + 3);
      for (int b = 0; b < 8; b++)
        c = c[7] ? ((c << 1) ^ `CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // Starts a cycle and polls until busy drops, timing the whole run.
  task automatic run_cycle(input logic [7:0] cmd, input int span);
    logic [7:0] d;
    int t0;
    i_host.unlock();
    i_host.wr(`ADDR_NV_CTL, cmd);
    t0 = cycles;
    i_host.rd(`ADDR_NV_CTL, 1'b1, d);
    check("cycle start", cmd | 8'h04, d & 8'hdf);
    while (d[2] === 1'b1 && cycles - t0 < 200)
      i_host.rd(`ADDR_NV_CTL, 1'b1, d);
    check("cycle end", cmd & 8'h10, d & 8'hdf);
    check("cycle length", 8'h01,
          8'(cycles - t0 >= span && cycles - t0 <= span + 8));
  endtask

  task automatic t_reset();
    logic [7:0] d;
    i_host.rd(`ADDR_NV_CTL, 1'b1, d);
    check("control after reset", 8'h10, d & 8'hdf);
    i_host.rd(`ADDR_UNLOCK, 1'b1, d);
    check("unlock readback", 8'h00, d);
    i_host.rd(`ADDR_PROG_COUNT, 1'b1, d);
    check("count after reset", 8'h00, d);
  endtask

  task automatic t_locked();
    logic [7:0] d;
    i_host.wr(`ADDR_NV_CTL, 8'h13);
    i_host.rd(`ADDR_NV_CTL, 1'b1, d);
    check("start while locked", 8'h10, d & 8'hdf);
    i_host.unlock();
    i_host.rd(`ADDR_STORED_CRC, 1'b1, d);
    i_host.wr(`ADDR_NV_CTL, 8'h13);
    i_host.rd(`ADDR_NV_CTL, 1'b1, d);
    check("start after stale unlock", 8'h10, d & 8'hdf);
  endtask

  task automatic t_copy_prog();
    logic [7:0] d;
    foreach (live_mem[i])
      live_mem[i] = 8'(i * 7 + 3);
    i_host.wr(`ADDR_NV_CTL, 8'h50);
    i_host.rd(`ADDR_NV_CTL, 1'b1, d);
    check("copy running", 8'h50, d & 8'hdf);
    repeat (30) @(posedge ref_clk);
    i_host.rd(`ADDR_NV_CTL, 1'b1, d);
    check("copy done", 8'h10, d & 8'hdf);
    run_cycle(8'h11, PC);
    i_host.rd(`ADDR_PROG_COUNT, 1'b1, d);
    check("count after program", 8'h01, d);
    i_host.rd(`ADDR_STORED_CRC, 1'b1, d);
    check("stored crc", crc_ref(), d);
    run_cycle(8'h13, EC + PC);
    i_host.rd(`ADDR_PROG_COUNT, 1'b1, d);
    check("count after combined", 8'h02, d);
  endtask

  task automatic t_load();
    logic [7:0] d;
    logic [7:0] d0;
    i_host.rd(`ADDR_STORED_CRC, 1'b1, d0);
    check("stored crc kept", crc_ref(), d0);
    foreach (live_mem[i])
      live_mem[i] = 8'h00;
    i_host.wr(`ADDR_NV_CTL, 8'h18);
    i_host.rd(`ADDR_UNLOCK, 1'b0, d);
    check("read during load", d0, d);
    i_host.rd(`ADDR_LIVE_CRC, 1'b1, d);
    check("live crc", crc_ref(), d);
    i_host.rd(`ADDR_NV_CTL, 1'b1, d);
    check("crc error clear", 8'h10, d & 8'hff);
    check("live word 29", 8'(29 * 7 + 3), live_mem[29]);
  endtask

  task automatic t_erase();
    logic [7:0] d;
    run_cycle(8'h12, EC);
    i_host.rd(`ADDR_PROG_COUNT, 1'b1, d);
    check("count after erase", 8'h02, d);
    i_host.wr(`ADDR_NV_CTL, 8'h18);
    i_host.wr(`ADDR_STORED_CRC, 8'hff);
    i_host.rd(`ADDR_STORED_CRC, 1'b1, d);
    check("stored crc erased", 8'h00, d);
    check("live word 5 erased", 8'h00, live_mem[5]);
  endtask

  task automatic t_saturate();
    logic [7:0] d;
    repeat (253)
      run_cycle(8'h11, PC);
    i_host.rd(`ADDR_PROG_COUNT, 1'b1, d);
    check("count at top", 8'hff, d);
    run_cycle(8'h11, PC);
    i_host.rd(`ADDR_PROG_COUNT, 1'b1, d);
    check("count saturated", 8'hff, d);
  endtask

  // With automatic CRC off the staging byte is stored, so a load mismatches.
  task automatic t_crc_err();
    logic [7:0] d;
    run_cycle(8'h01, PC);
    i_host.rd(`ADDR_STORED_CRC, 1'b1, d);
    check("stored crc manual", 8'h00, d);
    i_host.wr(`ADDR_NV_CTL, 8'h08);
    i_host.rd(`ADDR_NV_CTL, 1'b1, d);
    check("crc error set", {2'b00, crc_ref() != 8'h00, 5'h00}, d);
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    foreach (live_mem[i])
      live_mem[i] = 8'h00;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_locked();
    t_copy_prog();
    t_load();
    t_erase();
    t_saturate();
    t_crc_err();
    give_verdict();
  end
endmodule
